// [byte_pairing.sv]
// Pairs upper and lower data bytes into register words and splits reads
module byte_pairing
  import chan_regs_pkg::*;
(
  input  wire logic              clk_sys,        // System clock
  input  wire logic              sys_rst,        // Synchronous reset, high
  input  wire logic              frame_start,    // Command byte present
  input  wire logic [ADDR_W-1:0] cmd_byte,       // Register address
  input  wire logic              byte_wr,        // Write data byte present
  input  wire logic [BYTE_W-1:0] wr_byte,        // Write data byte
  input  wire logic              byte_rd_req,    // Next read byte wanted
  output logic      [BYTE_W-1:0] rd_byte_q,      // Read data byte
  output logic                   rd_byte_valid_q, // Read byte strobe
  reg_word_if.pairing            bus             // Word side
);

  byte_phase_t       phase_q;
  logic [BYTE_W-1:0] upper_q;
  logic [BYTE_W-1:0] hold_q;
  logic [ADDR_W-1:0] addr_q;
  logic              wr_stb_q;
  logic [DATA_W-1:0] wdata_q;
  logic              byte_go;

  // A new command byte outranks a data byte in the same cycle
  assign byte_go   = (byte_wr || byte_rd_req) && !frame_start;
  assign bus.addr  = addr_q;
  assign bus.wr_stb = wr_stb_q;
  assign bus.wdata = wdata_q;

  // Address held for the whole frame
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      addr_q <= {ADDR_W{1'b0}};
    else if (frame_start)
      addr_q <= cmd_byte;
  end

  // Byte position, restarted by every command byte
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || frame_start)
      phase_q <= PH_UPPER;
    else if (byte_go)
    begin
      case (phase_q)
        PH_UPPER: phase_q <= PH_LOWER;
        PH_LOWER: phase_q <= PH_UPPER;
        default:  phase_q <= PH_UPPER;
      endcase
    end
  end

  // Upper byte waits for its partner; commit only on the lower byte
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      upper_q  <= BYTE_ZERO;
      wr_stb_q <= 1'b0;
      wdata_q  <= WORD_ZERO;
    end
    else
    begin
      wr_stb_q <= 1'b0;
      if (byte_wr && !frame_start && phase_q == PH_UPPER)
        upper_q <= wr_byte;
      if (byte_wr && !frame_start && phase_q == PH_LOWER)
      begin
        wr_stb_q <= 1'b1;
        wdata_q  <= {upper_q, wr_byte};
      end
    end
  end

  // Read snapshot at the upper byte keeps the pair coherent
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rd_byte_q       <= BYTE_ZERO;
      hold_q          <= BYTE_ZERO;
      rd_byte_valid_q <= 1'b0;
    end
    else
    begin
      rd_byte_valid_q <= byte_rd_req && !frame_start;
      if (byte_rd_req && !frame_start && phase_q == PH_UPPER)
      begin
        rd_byte_q <= bus.rdata[DATA_W-1:BYTE_W];
        hold_q    <= bus.rdata[BYTE_W-1:0];
      end
      else if (byte_rd_req && !frame_start)
        rd_byte_q <= hold_q;
    end
  end

  a_pair_commit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    byte_wr && !frame_start && phase_q == PH_LOWER
    |=> wr_stb_q && wdata_q == {$past(upper_q), $past(wr_byte)})
    else $error("lower byte did not commit the paired word");

endmodule : byte_pairing

// [chan_regs_pkg.sv]
// Constants, field layout and types shared by the channel register bank
package chan_regs_pkg;

  // Widths of the access path and the stored fields
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned CODE_W     = 12;
  localparam int unsigned GAIN_W     = 3;
  localparam int unsigned CMP_CTRL_W = 5;

  // Register addresses as carried by the command byte
  localparam logic [ADDR_W-1:0] ADDR_NO_OPERATION    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CH2_MARGIN_HIGH = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_CH2_MARGIN_LOW  = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_CH2_CURR_GAIN   = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_CH0_MARGIN_HIGH = 8'h0D;
  localparam logic [ADDR_W-1:0] ADDR_CH0_MARGIN_LOW  = 8'h0E;
  localparam logic [ADDR_W-1:0] ADDR_CH0_GAIN_SELECT = 8'h0F;
  localparam logic [ADDR_W-1:0] ADDR_CH1_MARGIN_HIGH = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_CH1_MARGIN_LOW  = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_CH1_GAIN_CMP    = 8'h15;

  // Field positions inside the 16-bit word
  localparam int unsigned CODE_MSB     = 15;
  localparam int unsigned CODE_LSB     = 4;
  localparam int unsigned GAIN_MSB     = 12;
  localparam int unsigned GAIN_LSB     = 10;
  localparam int unsigned CMP_EN_BIT   = 0;
  localparam int unsigned CMP_INV_BIT  = 1;
  localparam int unsigned CMP_FB_BIT   = 2;
  localparam int unsigned CMP_PIN_BIT  = 3;
  localparam int unsigned CMP_OD_BIT   = 4;

  // Reset values
  localparam logic [DATA_W-1:0]     NO_OPERATION_VALUE = 16'h0000;
  localparam logic [CODE_W-1:0]     CODE_RESET         = 12'h000;
  localparam logic [GAIN_W-1:0]     GAIN_RESET         = 3'h0;
  localparam logic [CMP_CTRL_W-1:0] CMP_CTRL_RESET     = 5'h00;
  localparam logic [BYTE_W-1:0]     BYTE_ZERO          = 8'h00;
  localparam logic [DATA_W-1:0]     WORD_ZERO          = 16'h0000;

  // Gain codes: voltage channels valid from 1x supply to 4x internal
  localparam logic [GAIN_W-1:0] VGAIN_SUPPLY_1X   = 3'h1;
  localparam logic [GAIN_W-1:0] VGAIN_INTERNAL_4X = 3'h5;
  localparam logic [GAIN_W-1:0] IGAIN_TWO_THIRDS  = 3'h0;
  localparam logic [GAIN_W-1:0] IGAIN_ONE_HALF    = 3'h1;

  // Byte position within a data word, upper byte first
  typedef enum logic [1:0] {
    PH_UPPER = 2'b01,
    PH_LOWER = 2'b10
  } byte_phase_t;

endpackage : chan_regs_pkg

// [dac_channel_config_regs.sv]
// Per-channel margin and gain settings, plus the channel 1 comparator settings, of a three-channel front end
module dac_channel_config_regs
  import chan_regs_pkg::*;
(
  input  wire logic              clk_sys,                     // System clock
  input  wire logic              sys_rst,                     // Sync reset, high
  input  wire logic              frame_start,                 // Command byte present
  input  wire logic [ADDR_W-1:0] cmd_byte,                    // Register address
  input  wire logic              byte_wr,                     // Write byte present
  input  wire logic [BYTE_W-1:0] wr_byte,                     // Write data byte
  input  wire logic              byte_rd_req,                 // Read byte wanted
  input  wire logic              chan1_powered,               // Channel 1 enabled
  input  wire logic              chan1_adc_mode,              // Channel 1 analog input
  input  wire logic              cmp_raw,                     // Raw comparator level
  input  wire logic              chan1_output_pin_in,         // Pin level, unused here
  output logic      [BYTE_W-1:0] rd_byte_q,                   // Read data byte
  output logic                   rd_byte_valid_q,             // Read byte strobe
  output logic      [CODE_W-1:0] chan0_margin_high_q,         // Channel 0 high code
  output logic      [CODE_W-1:0] chan0_margin_low_q,          // Channel 0 low code
  output logic      [CODE_W-1:0] chan1_margin_high_q,         // Channel 1 high code
  output logic      [CODE_W-1:0] chan1_margin_low_q,          // Channel 1 low code
  output logic      [CODE_W-1:0] chan2_margin_high_q,         // Channel 2 high code
  output logic      [CODE_W-1:0] chan2_margin_low_q,          // Channel 2 low code
  output logic      [GAIN_W-1:0] chan0_gain_q,                // Channel 0 ref/gain
  output logic      [GAIN_W-1:0] chan1_gain_q,                // Channel 1 ref/gain
  output logic      [GAIN_W-1:0] current_output_gain_q,       // Channel 2 gain
  output logic                   chan0_gain_valid_q,          // Channel 0 code legal
  output logic                   chan1_gain_valid_q,          // Channel 1 code legal
  output logic                   current_gain_valid_q,        // Channel 2 code legal
  output logic                   cmp_result_q,                // Internal comparator
  output logic                   feedback_finite_impedance_q, // Feedback load on
  output logic                   comparator_open_drain_q,     // Pin in open-drain
  output logic                   chan1_output_pin_out_q,      // Pin drive level
  output logic                   chan1_output_pin_oe_n_q      // Pin driven when low
);

  reg_word_if bus ();

  logic [CMP_CTRL_W-1:0] cmp_ctrl_q;
  logic [DATA_W-1:0]     rdata;
  logic                  cmp_active;
  logic                  cmp_level;

  // Serial bytes to register words
  byte_pairing u_pairing (
    .clk_sys         (clk_sys),
    .sys_rst         (sys_rst),
    .frame_start     (frame_start),
    .cmd_byte        (cmd_byte),
    .byte_wr         (byte_wr),
    .wr_byte         (wr_byte),
    .byte_rd_req     (byte_rd_req),
    .rd_byte_q       (rd_byte_q),
    .rd_byte_valid_q (rd_byte_valid_q),
    .bus             (bus)
  );

  // Write hit on one address
  function automatic logic wr_hit(input logic stb, input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] target);
    wr_hit = stb && (a == target);
  endfunction : wr_hit

  // Left-justified code field of a data word
  function automatic logic [CODE_W-1:0] code_field(input logic [DATA_W-1:0] w);
    code_field = w[CODE_MSB:CODE_LSB];
  endfunction : code_field

  // Code placed back in its word, don't-care bits read as zero
  function automatic logic [DATA_W-1:0] code_word(input logic [CODE_W-1:0] c);
    code_word = {c, {CODE_LSB{1'b0}}};
  endfunction : code_word

  // Gain field placed back in its word
  function automatic logic [DATA_W-1:0] gain_word(input logic [GAIN_W-1:0] g);
    gain_word = WORD_ZERO;
    gain_word[GAIN_MSB:GAIN_LSB] = g;
  endfunction : gain_word

  // Voltage gain legal range: 1x supply through 4x internal
  function automatic logic vgain_valid(input logic [GAIN_W-1:0] g);
    vgain_valid = (g >= VGAIN_SUPPLY_1X) && (g <= VGAIN_INTERNAL_4X);
  endfunction : vgain_valid

  // Margin-high codes; low nibble of the word dropped on write
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      chan0_margin_high_q <= CODE_RESET;
      chan1_margin_high_q <= CODE_RESET;
      chan2_margin_high_q <= CODE_RESET;
    end
    else
    begin
      if (wr_hit(bus.wr_stb, bus.addr, ADDR_CH0_MARGIN_HIGH))
        chan0_margin_high_q <= code_field(bus.wdata);
      if (wr_hit(bus.wr_stb, bus.addr, ADDR_CH1_MARGIN_HIGH))
        chan1_margin_high_q <= code_field(bus.wdata);
      if (wr_hit(bus.wr_stb, bus.addr, ADDR_CH2_MARGIN_HIGH))
        chan2_margin_high_q <= code_field(bus.wdata);
    end
  end

  // Margin-low codes
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      chan0_margin_low_q <= CODE_RESET;
      chan1_margin_low_q <= CODE_RESET;
      chan2_margin_low_q <= CODE_RESET;
    end
    else
    begin
      if (wr_hit(bus.wr_stb, bus.addr, ADDR_CH0_MARGIN_LOW))
        chan0_margin_low_q <= code_field(bus.wdata);
      if (wr_hit(bus.wr_stb, bus.addr, ADDR_CH1_MARGIN_LOW))
        chan1_margin_low_q <= code_field(bus.wdata);
      if (wr_hit(bus.wr_stb, bus.addr, ADDR_CH2_MARGIN_LOW))
        chan2_margin_low_q <= code_field(bus.wdata);
    end
  end

  // Gain fields stored as written, legal or not, so software can read back
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      chan0_gain_q          <= GAIN_RESET;
      chan1_gain_q          <= GAIN_RESET;
      current_output_gain_q <= GAIN_RESET;
    end
    else
    begin
      if (wr_hit(bus.wr_stb, bus.addr, ADDR_CH0_GAIN_SELECT))
        chan0_gain_q <= bus.wdata[GAIN_MSB:GAIN_LSB];
      if (wr_hit(bus.wr_stb, bus.addr, ADDR_CH1_GAIN_CMP))
        chan1_gain_q <= bus.wdata[GAIN_MSB:GAIN_LSB];
      if (wr_hit(bus.wr_stb, bus.addr, ADDR_CH2_CURR_GAIN))
        current_output_gain_q <= bus.wdata[GAIN_MSB:GAIN_LSB];
    end
  end

  // Comparator control bits share the channel 1 gain word
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cmp_ctrl_q <= CMP_CTRL_RESET;
    else if (wr_hit(bus.wr_stb, bus.addr, ADDR_CH1_GAIN_CMP))
      cmp_ctrl_q <= bus.wdata[CMP_CTRL_W-1:0];
  end

  // Legality flags; downstream analog must not act on an illegal code
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      chan0_gain_valid_q   <= 1'b0;
      chan1_gain_valid_q   <= 1'b0;
      current_gain_valid_q <= 1'b1;
    end
    else
    begin
      chan0_gain_valid_q   <= vgain_valid(chan0_gain_q);
      chan1_gain_valid_q   <= vgain_valid(chan1_gain_q);
      current_gain_valid_q <= (current_output_gain_q == IGAIN_TWO_THIRDS) ||
                              (current_output_gain_q == IGAIN_ONE_HALF);
    end
  end

  // Read mux; no-operation and unmapped addresses read zero
  always_comb
  begin
    if (bus.addr == ADDR_NO_OPERATION)
      rdata = NO_OPERATION_VALUE;
    else if (bus.addr == ADDR_CH0_MARGIN_HIGH)
      rdata = code_word(chan0_margin_high_q);
    else if (bus.addr == ADDR_CH0_MARGIN_LOW)
      rdata = code_word(chan0_margin_low_q);
    else if (bus.addr == ADDR_CH1_MARGIN_HIGH)
      rdata = code_word(chan1_margin_high_q);
    else if (bus.addr == ADDR_CH1_MARGIN_LOW)
      rdata = code_word(chan1_margin_low_q);
    else if (bus.addr == ADDR_CH2_MARGIN_HIGH)
      rdata = code_word(chan2_margin_high_q);
    else if (bus.addr == ADDR_CH2_MARGIN_LOW)
      rdata = code_word(chan2_margin_low_q);
    else if (bus.addr == ADDR_CH0_GAIN_SELECT)
      rdata = gain_word(chan0_gain_q);
    else if (bus.addr == ADDR_CH1_GAIN_CMP)
      rdata = gain_word(chan1_gain_q) | {{(DATA_W-CMP_CTRL_W){1'b0}}, cmp_ctrl_q};
    else if (bus.addr == ADDR_CH2_CURR_GAIN)
      rdata = gain_word(current_output_gain_q);
    else
      rdata = WORD_ZERO;
  end

  assign bus.rdata = rdata;

  // Comparator runs only with the channel itself powered
  assign cmp_active = cmp_ctrl_q[CMP_EN_BIT] && chan1_powered;
  assign cmp_level  = cmp_raw ^ cmp_ctrl_q[CMP_INV_BIT];

  // Internal comparator result, low while the comparator is off
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cmp_result_q <= 1'b0;
    else
      cmp_result_q <= cmp_active && cmp_level;
  end

  // Feedback load forced off in analog-input mode to protect the input
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      feedback_finite_impedance_q <= 1'b0;
    else
      feedback_finite_impedance_q <= cmp_ctrl_q[CMP_FB_BIT] && !chan1_adc_mode;
  end

  // Pin driver: released unless the result is routed out
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      chan1_output_pin_out_q  <= 1'b0;
      chan1_output_pin_oe_n_q <= 1'b1;
      comparator_open_drain_q <= 1'b0;
    end
    else if (cmp_active && cmp_ctrl_q[CMP_PIN_BIT])
    begin
      comparator_open_drain_q <= cmp_ctrl_q[CMP_OD_BIT];
      if (cmp_ctrl_q[CMP_OD_BIT])
      begin
        chan1_output_pin_out_q  <= 1'b0;
        chan1_output_pin_oe_n_q <= cmp_level;  // Release for a high result
      end
      else
      begin
        chan1_output_pin_out_q  <= cmp_level;
        chan1_output_pin_oe_n_q <= 1'b0;
      end
    end
    else
    begin
      chan1_output_pin_out_q  <= 1'b0;
      chan1_output_pin_oe_n_q <= 1'b1;
      comparator_open_drain_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_nop_reads_zero: assert property (bus.addr == ADDR_NO_OPERATION |-> rdata == WORD_ZERO)
    else $error("no-operation word read nonzero");

  a_high_code_write: assert property (bus.wr_stb && bus.addr == ADDR_CH0_MARGIN_HIGH
    |=> chan0_margin_high_q == $past(bus.wdata[CODE_MSB:CODE_LSB]))
    else $error("channel 0 margin-high not stored");

  a_low_code_write: assert property (bus.wr_stb && bus.addr == ADDR_CH2_MARGIN_LOW
    |=> chan2_margin_low_q == $past(bus.wdata[CODE_MSB:CODE_LSB]))
    else $error("channel 2 margin-low not stored");

  a_code_left_just: assert property (bus.addr == ADDR_CH1_MARGIN_HIGH
    |-> rdata[CODE_MSB:CODE_LSB] == chan1_margin_high_q)
    else $error("margin code not left-justified");

  a_low_bits_zero: assert property (rdata[CODE_LSB-1:0] == '0 || bus.addr == ADDR_CH1_GAIN_CMP)
    else $error("ignored low bits read back");

  a_gain_legal: assert property (##1 chan0_gain_valid_q ==
    ($past(chan0_gain_q) >= VGAIN_SUPPLY_1X && $past(chan0_gain_q) <= VGAIN_INTERNAL_4X))
    else $error("channel 0 gain legality wrong");

  a_gain_cmp_write: assert property (bus.wr_stb && bus.addr == ADDR_CH1_GAIN_CMP
    |=> chan1_gain_q == $past(bus.wdata[GAIN_MSB:GAIN_LSB]))
    else $error("channel 1 gain not stored");

  a_cmp_unpowered: assert property (!chan1_powered
    |=> !cmp_result_q && chan1_output_pin_oe_n_q)
    else $error("comparator active while channel off");

  a_cmp_invert: assert property (cmp_active
    |=> cmp_result_q == ($past(cmp_raw) ^ $past(cmp_ctrl_q[CMP_INV_BIT])))
    else $error("comparator polarity wrong");

  a_fb_adc_mode: assert property (chan1_adc_mode |=> !feedback_finite_impedance_q)
    else $error("feedback load on in analog-input mode");

  a_pin_released: assert property (!cmp_ctrl_q[CMP_PIN_BIT] |=> chan1_output_pin_oe_n_q)
    else $error("pin driven without routing");

  a_od_drives_low: assert property (comparator_open_drain_q && !chan1_output_pin_oe_n_q
    |-> !chan1_output_pin_out_q)
    else $error("open-drain pin driven high");

  a_igain_legal: assert property (##1 current_gain_valid_q ==
    ($past(current_output_gain_q) <= IGAIN_ONE_HALF))
    else $error("current gain legality wrong");

endmodule : dac_channel_config_regs

// [dac_channel_config_regs_tb.sv]
// Self-checking bench for the channel register bank
module dac_channel_config_regs_tb
  import chan_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys = 1'b0;
  logic              sys_rst;
  logic              chan1_powered;
  logic              chan1_adc_mode;
  logic              cmp_raw;
  logic              frame_start, byte_wr, byte_rd_req, rd_byte_valid_q;
  logic [ADDR_W-1:0] cmd_byte;
  logic [BYTE_W-1:0] wr_byte, rd_byte_q;
  logic [CODE_W-1:0] chan0_margin_high_q, chan0_margin_low_q, chan1_margin_high_q;
  logic [CODE_W-1:0] chan1_margin_low_q, chan2_margin_high_q, chan2_margin_low_q;
  logic [GAIN_W-1:0] chan0_gain_q, chan1_gain_q, current_output_gain_q;
  logic              chan0_gain_valid_q, chan1_gain_valid_q, current_gain_valid_q;
  logic              cmp_result_q, feedback_finite_impedance_q, comparator_open_drain_q;
  logic              chan1_output_pin_out_q, chan1_output_pin_oe_n_q;
  wire logic         chan1_output_pin_in;
  int                fail_count;
  int                checks;

  // Pin level with a pull-up when released
  assign chan1_output_pin_in = chan1_output_pin_oe_n_q ? 1'b1 : chan1_output_pin_out_q;

  always #4 clk_sys = ~clk_sys;

  host_model host_u (.clk_sys, .frame_start, .cmd_byte, .byte_wr, .wr_byte,
    .byte_rd_req, .rd_byte_q, .rd_byte_valid_q);

  dac_channel_config_regs dut_u (.clk_sys, .sys_rst, .frame_start, .cmd_byte,
    .byte_wr, .wr_byte, .byte_rd_req, .chan1_powered, .chan1_adc_mode, .cmp_raw,
    .chan1_output_pin_in, .rd_byte_q, .rd_byte_valid_q, .chan0_margin_high_q,
    .chan0_margin_low_q, .chan1_margin_high_q, .chan1_margin_low_q,
    .chan2_margin_high_q, .chan2_margin_low_q, .chan0_gain_q, .chan1_gain_q,
    .current_output_gain_q, .chan0_gain_valid_q, .chan1_gain_valid_q,
    .current_gain_valid_q, .cmp_result_q, .feedback_finite_impedance_q,
    .comparator_open_drain_q, .chan1_output_pin_out_q, .chan1_output_pin_oe_n_q);

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_check(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] w;
    host_u.read_word(addr, w);
    check(w, exp);
  endtask : rd_check

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial
  begin
    static logic [ADDR_W-1:0] regs [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0D, 8'h0E, 8'h0F,
                                            8'h13, 8'h14, 8'h15};
    static logic [ADDR_W-1:0] margins [6] = '{8'h01, 8'h02, 8'h0D, 8'h0E, 8'h13, 8'h14};
    logic [DATA_W-1:0] w;
    logic              act;
    logic              lvl;
    logic [1:0]        pe;
    sys_rst        = 1'b1;
    chan1_powered  = 1'b0;
    chan1_adc_mode = 1'b0;
    cmp_raw        = 1'b0;
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    foreach (regs[i]) rd_check(regs[i], WORD_ZERO);
    check(16'(chan1_output_pin_oe_n_q), 16'h0001);
    check(16'({chan0_gain_valid_q, current_gain_valid_q}), 16'h0001);
    // Margin words carry junk in the low nibble, which must drop
    foreach (margins[i]) host_u.write_word(margins[i], {margins[i], 8'h5F});
    foreach (margins[i]) rd_check(margins[i], {margins[i], 8'h50});
    host_u.write_word(ADDR_NO_OPERATION, 16'hFFFF);
    host_u.write_word(8'h30, 16'hFFFF);
    rd_check(ADDR_NO_OPERATION, WORD_ZERO);
    rd_check(8'h30, WORD_ZERO);
    check(16'(chan0_margin_high_q), 16'h00D5);
    check(16'(chan2_margin_low_q), 16'h0025);
    check(16'(chan1_margin_high_q), 16'h0135);
    check(16'(chan0_margin_low_q), 16'h00E5);
    check(16'(chan1_margin_low_q), 16'h0145);
    check(16'(chan2_margin_high_q), 16'h0015);
    // Every gain code, invalid ones included, with don't-care bits set
    for (int c = 0; c < 8; c++)
    begin
      w = 16'(c) << GAIN_LSB;
      host_u.write_word(ADDR_CH0_GAIN_SELECT, w | 16'hE3FF);
      host_u.write_word(ADDR_CH2_CURR_GAIN, w | 16'hE3FF);
      host_u.write_word(ADDR_CH1_GAIN_CMP, w | 16'hE3E0);
      repeat (3) @(negedge clk_sys);
      rd_check(ADDR_CH0_GAIN_SELECT, w);
      rd_check(ADDR_CH2_CURR_GAIN, w);
      check(16'(chan0_gain_valid_q), 16'(c >= 1 && c <= 5));
      check(16'(chan1_gain_valid_q), 16'(c >= 1 && c <= 5));
      check(16'(chan1_gain_q), 16'(c));
      check(16'(chan0_gain_q), 16'(c));
      check(16'(current_output_gain_q), 16'(c));
      check(16'(current_gain_valid_q), 16'(c < 2));
    end
    // All comparator controls against power, raw level and input mode
    for (int k = 0; k < 128; k++)
    begin
      chan1_powered  = k[5];
      cmp_raw        = k[6];
      chan1_adc_mode = k[0] ^ k[6];
      host_u.write_word(ADDR_CH1_GAIN_CMP, 16'(k[4:0]) | 16'h0400);
      repeat (3) @(negedge clk_sys);
      act = k[0] & k[5];
      lvl = (k[6] ^ k[1]) & act;
      pe  = !(act && k[3]) ? 2'b01 : (k[4] ? {1'b0, lvl} : {lvl, 1'b0});
      check(16'(cmp_result_q), 16'(lvl));
      check(16'(feedback_finite_impedance_q), 16'(k[2] & ~chan1_adc_mode));
      check({14'h0, chan1_output_pin_out_q, chan1_output_pin_oe_n_q}, 16'(pe));
      check(16'(comparator_open_drain_q), 16'(act & k[3] & k[4]));
      rd_check(ADDR_CH1_GAIN_CMP, 16'(k[4:0]) | 16'h0400);
    end
    // A second reset in mid-run clears stored codes
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    rd_check(ADDR_CH0_MARGIN_HIGH, WORD_ZERO);
    give_verdict();
  end

  // Watchdog well beyond the under two thousand cycles the sequence needs
  initial
  begin
    #(20000 * 8);
    fail_count++;
    give_verdict();
  end
endmodule : dac_channel_config_regs_tb

// [host_model.sv]
// Host-side model that frames register words into command and data bytes
module host_model
  import chan_regs_pkg::*;
(
  input  wire logic              clk_sys,        // System clock
  output logic                   frame_start,    // Command byte strobe
  output logic      [ADDR_W-1:0] cmd_byte,       // Register address
  output logic                   byte_wr,        // Write byte strobe
  output logic      [BYTE_W-1:0] wr_byte,        // Write data byte
  output logic                   byte_rd_req,    // Read byte request
  input  wire logic [BYTE_W-1:0] rd_byte_q,      // Read data byte
  input  wire logic              rd_byte_valid_q // Read byte strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle values; released buses show the inverse, never the old byte
  initial
  begin
    frame_start = 1'b0;
    byte_wr     = 1'b0;
    byte_rd_req = 1'b0;
    cmd_byte    = 8'h5A;
    wr_byte     = 8'hA5;
  end

  // Command byte selects the register
  task automatic open_frame(input logic [ADDR_W-1:0] addr);
    @(negedge clk_sys);
    frame_start = 1'b1;
    cmd_byte    = addr;
    @(negedge clk_sys);
    frame_start = 1'b0;
    cmd_byte    = ~addr;
  endtask : open_frame

  // Upper byte then lower byte, back to back
  task automatic write_word(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    open_frame(addr);
    byte_wr = 1'b1;
    wr_byte = data[15:8];
    @(negedge clk_sys);
    wr_byte = data[7:0];
    @(negedge clk_sys);
    byte_wr = 1'b0;
    wr_byte = ~data[7:0];
  endtask : write_word

  // A byte arriving without its strobe reads as unknown, so it never matches
  task automatic read_word(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data);
    open_frame(addr);
    byte_rd_req = 1'b1;
    @(negedge clk_sys);
    data[15:8] = rd_byte_valid_q ? rd_byte_q : 8'hXX;
    @(negedge clk_sys);
    byte_rd_req = 1'b0;
    data[7:0] = rd_byte_valid_q ? rd_byte_q : 8'hXX;
  endtask : read_word
endmodule : host_model

// [reg_word_if.sv]
// Word-level register access between byte pairing and the register bank
interface reg_word_if;
  import chan_regs_pkg::*;

  logic              wr_stb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;

  modport pairing (output wr_stb, output addr, output wdata, input rdata);
  modport regs    (input wr_stb, input addr, input wdata, output rdata);
endinterface : reg_word_if
